/* File: pbs_pkg.sv */
// Constants shared by the status/command middle bits register bank.
//
// Operation
// - Decode-select timing field is read-only and always reads 01; medium timing used.
// - Master controller sets parity-reported flag on parity error during its own cycle.
// - Parity-reported flag clears on a software write of one to it in a cycle with no set, or on system or bus reset.
// - Fast back-to-back capability bit is read-only and always reads one.
// - User-definable-features support bit is read-only and always reads zero.
// - High-speed capability bit is read-only and always reads zero.
// - System-error enable is fixed at zero; the bridge never drives the error pin.
// - With parity response disabled, data parity errors never set the flag.
// - System reset or bus reset returns the whole register to reset values.
package pbs_pkg;

  // Configuration register number of the status/command register.
  localparam logic [5:0] PBS_REG_NUM = 6'h01;

  // Field positions.
  localparam int PBS_DEVSEL_LSB = 25;
  localparam int PBS_DEVSEL_MSB = 26;
  localparam int PBS_DPR_BIT = 24;
  localparam int PBS_FB2B_BIT = 23;
  localparam int PBS_UDF_BIT = 22;
  localparam int PBS_HS_BIT = 21;
  localparam int PBS_SERR_EN_BIT = 8;
  localparam int PBS_PRE_BIT = 6;

  // Fixed and reset values.
  localparam logic [1:0] PBS_DEVSEL_MEDIUM = 2'h1;
  localparam logic PBS_FB2B_VAL = 1'b1;
  localparam logic PBS_UDF_VAL = 1'b0;
  localparam logic PBS_HS_VAL = 1'b0;
  localparam logic PBS_SERR_EN_VAL = 1'b0;
  localparam logic PBS_DPR_RST = 1'b0;
  localparam logic PBS_PRE_RST = 1'b0;
  localparam logic [31:0] PBS_ZERO_WORD = 32'h0000_0000;

endpackage

/* File: pbs_sticky_flag.sv */
// Sticky status flag with write-one-to-clear and a synchronous reset.
`timescale 1ns/1ps
`default_nettype none

module pbs_sticky_flag #(
  parameter logic RESET_VALUE = 1'b0
) (
  input wire logic clock, // System clock.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic sync_clear, // Synchronous reset, such as a bus reset.
  input wire logic set_event, // Hardware event that sets the flag.
  input wire logic clear_req, // Software write of one to the flag.
  output logic flag_r // Current flag value.
);

  logic flag_nxt;

  // A set in the same cycle as a clear wins, so no event is lost.
  always_comb begin
    flag_nxt = flag_r;
    if (sync_clear) begin
      flag_nxt = RESET_VALUE;
    end else if (set_event) begin
      flag_nxt = 1'b1;
    end else if (clear_req) begin
      flag_nxt = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      flag_r <= RESET_VALUE;
    end else begin
      flag_r <= flag_nxt;
    end
  end

endmodule

`default_nettype wire

/* File: pbs_status_cmd.sv */
// Middle status/command bits of the host bridge configuration register.
`timescale 1ns/1ps
`default_nettype none

module pbs_status_cmd (
  input wire logic clock, // System clock, 20 MHz.
  input wire logic rst_n, // System reset, asynchronous, active low.
  input wire logic bus_reset, // Bridge bus reset, one or more cycles.
  input wire logic cfg_wr, // Configuration write strobe.
  input wire logic cfg_rd, // Configuration read strobe.
  input wire logic [5:0] cfg_reg_num, // Configuration register number.
  input wire logic [3:0] cfg_be, // Byte enables for a write.
  input wire logic [31:0] cfg_wdata, // Write data.
  input wire logic master_cycle, // Bridge master owns the current bus cycle.
  input wire logic perr_n_pin, // Parity error pin, active low.
  input wire logic own_perr, // Bridge itself signals a data parity error.
  output logic [31:0] cfg_rdata, // Read data, valid with cfg_rvalid.
  output logic cfg_rvalid, // Read answer, one-cycle pulse.
  output logic [1:0] devsel_timing, // Decode timing used by the target.
  output logic fast_b2b_capable, // Target accepts fast back-to-back.
  output logic data_parity_reported, // Sticky data parity flag.
  output logic parity_response_enable, // Parity response control.
  output logic serr_n_out, // Error pin output level.
  output logic serr_n_oe // Error pin output enable, high drives.
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser: the first stage feeds only the second.

  logic perr_meta_r;
  logic perr_sync_r;
  logic perr_meta_nxt;
  logic perr_sync_nxt;

  always_comb begin
    perr_meta_nxt = ~perr_n_pin;
    perr_sync_nxt = perr_meta_r;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      perr_meta_r <= 1'b0;
      perr_sync_r <= 1'b0;
    end else begin
      perr_meta_r <= perr_meta_nxt;
      perr_sync_r <= perr_sync_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Access decode.

  logic hit;
  logic wr_b0;
  logic wr_b3;
  logic dpr_clear;
  logic dpr_set;

  always_comb begin
    hit = (cfg_reg_num == pbs_pkg::PBS_REG_NUM);
    wr_b0 = cfg_wr && hit && cfg_be[0];
    wr_b3 = cfg_wr && hit && cfg_be[3];
    // Only bit 24 of byte 3 is writable; other written bits are dropped.
    dpr_clear = wr_b3 && cfg_wdata[pbs_pkg::PBS_DPR_BIT];
    // The bridge's own error counts at once; the pin is seen two cycles late,
    // so a master cycle that ends quickly may miss a late pin report.
    dpr_set = parity_response_enable && master_cycle &&
              (perr_sync_r || own_perr);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Parity response control, bit 6.

  logic pre_nxt;

  always_comb begin
    pre_nxt = parity_response_enable;
    if (bus_reset) begin
      pre_nxt = pbs_pkg::PBS_PRE_RST;
    end else if (wr_b0) begin
      pre_nxt = cfg_wdata[pbs_pkg::PBS_PRE_BIT];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      parity_response_enable <= pbs_pkg::PBS_PRE_RST;
    end else begin
      parity_response_enable <= pre_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data parity reported flag, bit 24.

  pbs_sticky_flag #(
    .RESET_VALUE(pbs_pkg::PBS_DPR_RST)
  ) u_dpr (
    .clock(clock),
    .rst_n(rst_n),
    .sync_clear(bus_reset),
    .set_event(dpr_set),
    .clear_req(dpr_clear),
    .flag_r(data_parity_reported)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read path and fixed outputs.

  logic [31:0] rdata_nxt;
  logic rvalid_nxt;
  logic [31:0] word;

  always_comb begin
    word = pbs_pkg::PBS_ZERO_WORD;
    // Reserved bits 20..9 and 7 always read zero whatever was written.
    word[pbs_pkg::PBS_DEVSEL_MSB:pbs_pkg::PBS_DEVSEL_LSB] =
      pbs_pkg::PBS_DEVSEL_MEDIUM;
    word[pbs_pkg::PBS_DPR_BIT] = data_parity_reported;
    word[pbs_pkg::PBS_FB2B_BIT] = pbs_pkg::PBS_FB2B_VAL;
    word[pbs_pkg::PBS_UDF_BIT] = pbs_pkg::PBS_UDF_VAL;
    word[pbs_pkg::PBS_HS_BIT] = pbs_pkg::PBS_HS_VAL;
    word[pbs_pkg::PBS_SERR_EN_BIT] = pbs_pkg::PBS_SERR_EN_VAL;
    word[pbs_pkg::PBS_PRE_BIT] = parity_response_enable;
    rvalid_nxt = cfg_rd;
    rdata_nxt = cfg_rdata;
    if (cfg_rd) begin
      rdata_nxt = hit ? word : pbs_pkg::PBS_ZERO_WORD;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cfg_rdata <= pbs_pkg::PBS_ZERO_WORD;
      cfg_rvalid <= 1'b0;
      devsel_timing <= pbs_pkg::PBS_DEVSEL_MEDIUM;
      fast_b2b_capable <= pbs_pkg::PBS_FB2B_VAL;
      serr_n_out <= 1'b1;
      serr_n_oe <= 1'b0;
    end else begin
      cfg_rdata <= rdata_nxt;
      cfg_rvalid <= rvalid_nxt;
      devsel_timing <= pbs_pkg::PBS_DEVSEL_MEDIUM;
      fast_b2b_capable <= pbs_pkg::PBS_FB2B_VAL;
      serr_n_out <= 1'b1;
      serr_n_oe <= 1'b0;
    end
  end

endmodule

`default_nettype wire

/* File: pbs_sva.sv */
// Checker for the status/command middle bits register.
`timescale 1ns/1ps
`default_nettype none
module pbs_sva (
  input wire logic clock, // Seen.
  input wire logic rst_n, // Seen.
  input wire logic bus_reset, // Seen.
  input wire logic cfg_wr, // Seen.
  input wire logic cfg_rd, // Seen.
  input wire logic [5:0] cfg_reg_num, // Seen.
  input wire logic [3:0] cfg_be, // Seen.
  input wire logic [31:0] cfg_wdata, // Seen.
  input wire logic master_cycle, // Seen.
  input wire logic perr_n_pin, // Seen.
  input wire logic own_perr, // Seen.
  input wire logic [31:0] cfg_rdata, // Seen.
  input wire logic cfg_rvalid, // Seen.
  input wire logic fast_b2b_capable, // Seen.
  input wire logic [1:0] devsel_timing, // Seen.
  input wire logic data_parity_reported, // Seen.
  input wire logic parity_response_enable, // Seen.
  input wire logic serr_n_out, // Seen.
  input wire logic serr_n_oe // Seen.
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  wire w1c = cfg_wr && cfg_reg_num == 6'h01 && cfg_be[3] && cfg_wdata[24];
  wire en = parity_response_enable && master_cycle && !bus_reset;
  // The pin crosses two sync stages, so it is held low for three edges.
  sequence s_pin_err;
    !perr_n_pin [*3] ##0 en;
  endsequence
  a_devsel_fixed: assert property (devsel_timing == 2'h1)
    else $error("devsel timing wrong");
  a_serr_idle: assert property (!serr_n_oe && serr_n_out)
    else $error("error pin driven");
  a_fb2b_fixed: assert property (fast_b2b_capable)
    else $error("fast back-to-back bit wrong");
  a_rvalid_pulse: assert property (cfg_rd |=> cfg_rvalid)
    else $error("read answer missing");
  a_read_word: assert property (cfg_rd && cfg_reg_num == 6'h01
    |=> cfg_rdata[26:7] == {2'h1, $past(data_parity_reported), 17'h10000})
    else $error("read word wrong");
  a_own_set: assert property (en && own_perr |=> data_parity_reported)
    else $error("own error not flagged");
  a_pin_set: assert property (s_pin_err |=> data_parity_reported)
    else $error("pin error not flagged");
  a_no_resp: assert property (!parity_response_enable &&
    !data_parity_reported |=> !data_parity_reported) else $error("flag set");
  a_flag_hold: assert property (data_parity_reported && !w1c &&
    !bus_reset |=> data_parity_reported) else $error("flag lost");
  a_flag_clear: assert property (w1c && !master_cycle &&
    !bus_reset |=> !data_parity_reported) else $error("flag not cleared");
  a_bus_reset: assert property (bus_reset |=>
    !data_parity_reported && !parity_response_enable) else $error("no reset");
endmodule
bind pbs_status_cmd pbs_sva u_sva (.*);
`default_nettype wire

/* File: pbs_pci_agent.sv */
// Bus agent model driving master cycles and parity errors.
`timescale 1ns/1ps
`default_nettype none
module pbs_pci_agent (
  input wire logic clock, // System clock.
  input wire logic go, // Start one bus cycle.
  input wire logic mst, // Cycle belongs to the bridge master.
  input wire logic [1:0] err, // Bit 0 pin error, bit 1 own error.
  output logic master_cycle, // Bridge master owns the cycle.
  output logic own_perr, // Bridge sees a parity error.
  output logic perr_n_pin // Parity error pin, pulled up.
);
  logic [2:0] cnt_r = 3'h0;
  logic mst_r = 1'b0;
  logic [1:0] err_r = 2'h0;
  // Sampling go on the rising edge keeps clear of the bench, which drives
  // go at the falling edge; outputs then change by non-blocking assignment.
  always @(posedge clock) begin
    if (go) begin
      cnt_r <= 3'h4;
      mst_r <= mst;
      err_r <= err;
    end else if (cnt_r != 3'h0) begin
      cnt_r <= cnt_r - 3'h1;
    end
  end
  assign master_cycle = mst_r && cnt_r != 3'h0;
  // Released between cycles, the pin returns to its pull-up level.
  assign perr_n_pin = !(err_r[0] && cnt_r != 3'h0);
  assign own_perr = err_r[1] && cnt_r == 3'h1;
endmodule
`default_nettype wire

/* File: tb_top.sv */
// Random and directed bench for the status/command middle bits register.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clock, rst_n, bus_reset, cfg_wr, cfg_rd, go, mst, flag_m, pre_m;
  logic cfg_rvalid, fast_b2b_capable, data_parity_reported, serr_n_out;
  logic parity_response_enable, serr_n_oe, master_cycle, own_perr, perr_n_pin;
  logic [5:0] cfg_reg_num;
  logic [3:0] cfg_be;
  logic [31:0] cfg_wdata, cfg_rdata, seed;
  logic [1:0] err, devsel_timing;
  int error_cnt = 0;
  int check_count = 0;
  pbs_status_cmd dut (.*);
  pbs_pci_agent agent (.*);
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [32:0] word(input logic [5:0] r);
    return r != 6'h01 ? 33'h100000000 : {8'h81, flag_m, 17'h10000, pre_m, 6'h00};
  endfunction
  task automatic rd(input logic [5:0] r);
    cfg_reg_num = r;
    cfg_rd = 1'b1;
    @(negedge clock);
    cfg_rd = 1'b0;
    check_count++;
    if ({cfg_rvalid, cfg_rdata} !== word(r)) begin
      error_cnt++;
      $display("Error t=%0t got=%h exp=%h", $time, cfg_rdata, word(r));
    end
  endtask
  task automatic wr(input logic [5:0] r, input logic [3:0] be, input logic [31:0] d);
    {cfg_reg_num, cfg_be, cfg_wdata, cfg_wr} = {r, be, d, 1'b1};
    if (r == 6'h01 && be[0]) pre_m = d[6];
    if (r == 6'h01 && be[3] && d[24]) flag_m = 1'b0;
    @(negedge clock);
    cfg_wr = 1'b0;
  endtask
  task automatic cyc(input logic m, input logic [1:0] e);
    {go, mst, err} = {1'b1, m, e};
    @(negedge clock);
    go = 1'b0;
    repeat (6) @(negedge clock);
    if (m && pre_m && e != 2'h0) flag_m = 1'b1;
  endtask
  task results;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    {rst_n, bus_reset, cfg_wr, cfg_rd, go, mst, flag_m, pre_m} = 8'h00;
    {err, cfg_reg_num, cfg_be, cfg_wdata} = '0;
    seed = 32'h4499E161;
    repeat (8) @(negedge clock);
    rst_n = 1'b1;
    rd(6'h01);
    wr(6'h01, 4'hF, 32'hFFE0017F);
    rd(6'h01);
    cyc(1'b1, 2'h1);
    rd(6'h01);
    wr(6'h01, 4'h7, 32'h01000040);
    rd(6'h01);
    wr(6'h01, 4'h8, 32'h01000000);
    cyc(1'b0, 2'h3);
    rd(6'h01);
    cyc(1'b1, 2'h2);
    wr(6'h01, 4'h9, 32'h01000000);
    cyc(1'b1, 2'h3);
    rd(6'h01);
    wr(6'h01, 4'h1, 32'h00000040);
    cyc(1'b1, 2'h2);
    bus_reset = 1'b1;
    @(negedge clock);
    {bus_reset, flag_m, pre_m} = 3'h0;
    rd(6'h01);
    repeat (40) begin
      seed = lfsr(seed);
      wr({5'h00, seed[0]}, seed[4:1], seed & 32'hFFE0017F);
      cyc(seed[5], seed[7:6]);
      rd({5'h00, seed[8]});
    end
    results;
  end
  initial begin
    #100000;
    error_cnt++;
    results;
  end
endmodule
`default_nettype wire
